// file: src/rstc_pkg.sv
// rstc_pkg: register map, field layout and shared types for the rail sequence / tracking block
// assumes a byte-oriented command port driven by the management interface front end
package rstc_pkg;
  localparam logic [7:0]  LOOP_RESPONSE_OFS   = 8'hdf;
  localparam logic [7:0]  RAIL_ORDER_OFS      = 8'he0;
  localparam logic [7:0]  VOLTAGE_FOLLOW_OFS  = 8'he1;
  localparam int          LOOP_EN_BIT         = 24;
  localparam int          LOOP_RES_MSB        = 23;
  localparam int          LOOP_RES_LSB        = 16;
  localparam int          LOOP_GAIN_MSB       = 15;
  localparam int          LOOP_GAIN_LSB       = 0;
  localparam logic [31:0] LOOP_WR_MASK        = 32'h01ff_ffff;
  localparam int          PRE_EN_BIT          = 15;
  localparam int          PRE_ID_MSB          = 12;
  localparam int          PRE_ID_LSB          = 8;
  localparam int          SEQ_EN_BIT          = 7;
  localparam int          SEQ_ID_MSB          = 4;
  localparam int          SEQ_ID_LSB          = 0;
  localparam logic [15:0] RAIL_ORDER_WR_MASK  = 16'h9f9f;
  localparam logic [15:0] RAIL_ORDER_RST      = 16'h0000;
  localparam int          FOLLOW_EN_BIT       = 7;
  localparam int          FOLLOW_HALF_BIT     = 2;
  localparam int          FOLLOW_CAP_BIT      = 1;
  localparam logic [7:0]  FOLLOW_WR_MASK      = 8'h86;
  localparam logic [7:0]  VOLTAGE_FOLLOW_RST  = 8'h00;
  localparam logic [1:0]  EVT_POWER_GOOD      = 2'h1;
  localparam logic [1:0]  EVT_POWER_DOWN      = 2'h2;

  typedef struct packed {
    logic        valid;
    logic [1:0]  kind;
    logic [4:0]  rail_id;
  } rstc_event_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } rstc_cmd_type;
endpackage

// file: src/rstc_rail_seq.sv
// rstc_rail_seq: loop response, rail order and voltage follow settings plus rail on/off sequencing
// assumes command, peer events, strap decodes and measurements arrive synchronous to CLK
// Behaviour
// [RULE_01] loop response: bit 24 enable, 23:16 residual, 15:0 gain, read-write
// [RULE_02] gain and residual auto-derived from input and output voltage unless overridden
// [RULE_03] loop response resets to the loop strap pin decode value; code sets bit 24 but gain and residual read AUTO values
// [RULE_04] host should keep gain near 100..1000 and residual near 10..90
// [RULE_05] turn on only when enabled and prequel has broadcast power good
// [RULE_06] turn off with delays after sequel broadcasts power down
// [RULE_07] rail order bit 15 prequel enable, bits 12:8 prequel rail id
// [RULE_08] rail order bit 7 sequel enable, bits 4:0 sequel rail id
// [RULE_09] rail order bits 14:13 and 6:5 read as zero
// [RULE_10] written rail order overrides the setup strap ordering
// [RULE_11] rail order resets to zero, both orderings disabled; code sequences from STRAP_ORDER until the first write
// [RULE_12] follow bit 7 enables tracking; byte resets to zero
// [RULE_13] tracking ratio 100% when bit 2 clear, 50% when set
// [RULE_14] bit 1 caps output at target or follow voltage; bits 6:3,0 unused
// [RULE_15] tracking only when not in a 4/6/8 phase group
// [RULE_16] host sets tracking turn-off delay above tracked delay plus fall
// [RULE_17] host sets output command to the steady-state voltage when tracking
// [RULE_18] prequel enabled and no power good seen keeps output off
`timescale 1ns/1ps
`default_nettype none
module rstc_rail_seq
  import rstc_pkg::*;
(
  input  wire logic           CLK,
  input  wire logic           NRST,
  input  wire rstc_cmd_type   CMD,
  output logic [31:0]         RDATA,
  output logic                RVALID,
  input  wire logic [7:0]     STRAP_RESIDUAL,
  input  wire logic [15:0]    STRAP_GAIN,
  input  wire logic [15:0]    STRAP_ORDER,
  input  wire logic [7:0]     AUTO_RESIDUAL,
  input  wire logic [15:0]    AUTO_GAIN,
  input  wire logic           ENABLE_STATE,
  input  wire logic           MULTI_GROUP,
  input  wire rstc_event_type PEER_EVT,
  input  wire logic           OFF_DELAY_DONE,
  input  wire logic [15:0]    TARGET_VOLT,
  input  wire logic [15:0]    FOLLOW_VOLT,
  output logic                RAIL_ON,
  output logic                OFF_DELAY_START,
  output logic                LOOP_GAIN_EN,
  output logic [7:0]          LOOP_RESIDUAL,
  output logic [15:0]         LOOP_GAIN,
  output logic                TRACK_ACTIVE,
  output logic [15:0]         VOLT_REF
);
  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_ON    = 2'b01,
    ST_DELAY = 2'b10
  } rstc_state_type;

  logic [31:0]    loop_q;
  logic           loop_init_q;
  logic           override_q;
  logic [15:0]    order_q;
  logic           order_wr_q;
  logic [7:0]     follow_q;
  logic           pg_seen_q;
  rstc_state_type st_q, st_d;

  wire wr_loop   = CMD.wr && CMD.addr == LOOP_RESPONSE_OFS;
  wire wr_order  = CMD.wr && CMD.addr == RAIL_ORDER_OFS;
  wire wr_follow = CMD.wr && CMD.addr == VOLTAGE_FOLLOW_OFS;

  // written order wins over the strap decode once software has touched it
  wire [15:0] order_eff = (order_wr_q ? order_q : STRAP_ORDER) & RAIL_ORDER_WR_MASK; // [RULE_10] [RULE_09]
  wire        pre_en  = order_eff[PRE_EN_BIT];                                      // [RULE_07]
  wire [4:0]  pre_id  = order_eff[PRE_ID_MSB:PRE_ID_LSB];
  wire        seq_en  = order_eff[SEQ_EN_BIT];                                      // [RULE_08]
  wire [4:0]  seq_id  = order_eff[SEQ_ID_MSB:SEQ_ID_LSB];
  wire pg_evt = PEER_EVT.valid && PEER_EVT.kind == EVT_POWER_GOOD && PEER_EVT.rail_id == pre_id;
  wire pd_evt = PEER_EVT.valid && PEER_EVT.kind == EVT_POWER_DOWN && PEER_EVT.rail_id == seq_id;
  wire pre_ok = !pre_en || pg_seen_q || pg_evt;                                     // [RULE_05] [RULE_18]
  wire want_off = !ENABLE_STATE || (seq_en && pd_evt);                              // [RULE_06]

  wire        track  = follow_q[FOLLOW_EN_BIT] && !MULTI_GROUP;                     // [RULE_12] [RULE_15]
  wire [15:0] scaled = follow_q[FOLLOW_HALF_BIT] ? {1'b0, FOLLOW_VOLT[15:1]} : FOLLOW_VOLT; // [RULE_13]
  wire [15:0] cap    = follow_q[FOLLOW_CAP_BIT] ? FOLLOW_VOLT : TARGET_VOLT;       // [RULE_14]
  wire [15:0] ref_d  = !track ? TARGET_VOLT : (scaled < cap ? scaled : cap);

  // until a user write, gain and residual follow the automatic derivation
  wire [7:0]  res_d  = override_q ? loop_q[LOOP_RES_MSB:LOOP_RES_LSB] : AUTO_RESIDUAL;  // [RULE_02]
  wire [15:0] gain_d = override_q ? loop_q[LOOP_GAIN_MSB:LOOP_GAIN_LSB] : AUTO_GAIN;

  logic [31:0] rd_mux;
  always_comb begin
    unique case (CMD.addr)
      LOOP_RESPONSE_OFS:  rd_mux = {loop_q[31:24], res_d, gain_d};
      // reads show the stored word; the strap order only steers sequencing
      RAIL_ORDER_OFS:     rd_mux = {16'h0000, order_q};                            // [RULE_11]
      VOLTAGE_FOLLOW_OFS: rd_mux = {24'h000000, follow_q & FOLLOW_WR_MASK};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_OFF:   if (ENABLE_STATE && pre_ok) st_d = ST_ON;                          // [RULE_05]
      ST_ON:    if (want_off) st_d = ST_DELAY;                                     // [RULE_06]
      ST_DELAY: if (OFF_DELAY_DONE) st_d = ST_OFF;
      default:  st_d = ST_OFF;
    endcase
  end

  // a write in the first cycle after reset still beats the strap capture
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      loop_q <= 32'h0000_0000;
    end else if (wr_loop) begin
      loop_q <= CMD.wdata & LOOP_WR_MASK;                                          // [RULE_01]
    end else if (!loop_init_q) begin
      // strap is caught on the first clock after reset release
      loop_q <= {7'h00, 1'b1, STRAP_RESIDUAL, STRAP_GAIN};                        // [RULE_03]
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      loop_init_q <= 1'b0;
    end else begin
      loop_init_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      override_q <= 1'b0;
    end else if (wr_loop) begin
      override_q <= 1'b1;                                                          // [RULE_02]
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      order_q <= RAIL_ORDER_RST;                                                   // [RULE_11]
    end else if (wr_order) begin
      order_q <= CMD.wdata[15:0] & RAIL_ORDER_WR_MASK;                             // [RULE_09]
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      order_wr_q <= 1'b0;
    end else if (wr_order) begin
      order_wr_q <= 1'b1;                                                          // [RULE_10]
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      follow_q <= VOLTAGE_FOLLOW_RST;                                              // [RULE_12]
    end else if (wr_follow) begin
      follow_q <= CMD.wdata[7:0] & FOLLOW_WR_MASK;                                 // [RULE_14]
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_q <= ST_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // a fresh power-good is needed for each power-up
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pg_seen_q <= 1'b0;
    end else if (st_q == ST_ON) begin
      pg_seen_q <= 1'b0;
    end else if (pg_evt) begin
      pg_seen_q <= 1'b1;                                                           // [RULE_18]
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RAIL_ON         <= 1'b0;
      OFF_DELAY_START <= 1'b0;
    end else begin
      RAIL_ON         <= st_d != ST_OFF;                                           // [RULE_05]
      OFF_DELAY_START <= st_q == ST_ON && st_d == ST_DELAY;                        // [RULE_06]
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      LOOP_GAIN_EN  <= 1'b0;
      LOOP_RESIDUAL <= 8'h00;
      LOOP_GAIN     <= 16'h0000;
    end else begin
      LOOP_GAIN_EN  <= loop_q[LOOP_EN_BIT];                                        // [RULE_01]
      LOOP_RESIDUAL <= res_d;
      LOOP_GAIN     <= gain_d;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      TRACK_ACTIVE <= 1'b0;
      VOLT_REF     <= 16'h0000;
    end else begin
      TRACK_ACTIVE <= track;                                                       // [RULE_15]
      VOLT_REF     <= ref_d;                                                       // [RULE_13]
    end
  end

  // read data holds until the next read so a slow host can still pick it up
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 32'h0000_0000;
    end else if (CMD.rd) begin
      RDATA <= rd_mux;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RVALID <= 1'b0;
    end else begin
      RVALID <= CMD.rd;
    end
  end
endmodule
`default_nettype wire

// file: testbench/rstc_chk.sv
// rstc_chk: port assertions for rstc_rail_seq
// assumes one CLK domain and NRST async active low
`timescale 1ns/1ps
`default_nettype none
module rstc_chk
  import rstc_pkg::*;
(
  input wire logic         CLK,
  input wire logic         NRST,
  input wire rstc_cmd_type CMD,
  input wire logic [31:0]  RDATA,
  input wire logic         RVALID,
  input wire logic         ENABLE_STATE,
  input wire logic         MULTI_GROUP,
  input wire logic         OFF_DELAY_DONE,
  input wire logic         RAIL_ON,
  input wire logic         OFF_DELAY_START,
  input wire logic         TRACK_ACTIVE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_rd(a); CMD.rd && CMD.addr == a; endsequence
  property p_rv; CMD.rd |=> RVALID; endproperty
  a_rv: assert property (p_rv) else $error("read unanswered");
  property p_loop; s_rd(LOOP_RESPONSE_OFS) |=> RDATA[31:25] == 7'h00; endproperty
  a_loop: assert property (p_loop) else $error("loop spare bits set");
  property p_ord; s_rd(RAIL_ORDER_OFS) |=> (RDATA & 32'hffff_6060) == 32'h0; endproperty
  a_ord: assert property (p_ord) else $error("order spare bits set");
  property p_fol; s_rd(VOLTAGE_FOLLOW_OFS) |=> (RDATA & 32'hffff_ff79) == 32'h0; endproperty
  a_fol: assert property (p_fol) else $error("follow spare bits set");
  property p_on; $rose(RAIL_ON) |-> $past(ENABLE_STATE); endproperty
  a_on: assert property (p_on) else $error("rail on without enable");
  property p_grp; MULTI_GROUP |=> !TRACK_ACTIVE; endproperty
  a_grp: assert property (p_grp) else $error("tracking in group");
  property p_off; OFF_DELAY_START |=> !OFF_DELAY_START; endproperty
  a_off: assert property (p_off) else $error("shutdown start not a pulse");
  property p_fall; $fell(RAIL_ON) |-> $past(OFF_DELAY_DONE); endproperty
  a_fall: assert property (p_fall) else $error("rail off before delay");
endmodule
bind rstc_rail_seq rstc_chk u_rstc_chk (.CLK(CLK), .NRST(NRST), .CMD(CMD), .RDATA(RDATA),
  .RVALID(RVALID), .ENABLE_STATE(ENABLE_STATE), .MULTI_GROUP(MULTI_GROUP),
  .OFF_DELAY_DONE(OFF_DELAY_DONE), .RAIL_ON(RAIL_ON), .OFF_DELAY_START(OFF_DELAY_START),
  .TRACK_ACTIVE(TRACK_ACTIVE));
`default_nettype wire

// file: testbench/rstc_peer_model.sv
// rstc_peer_model: peer rail controller broadcasting on the peer power bus
// assumes the bench raises req for one cycle after a rising clk edge
`timescale 1ns/1ps
`default_nettype none
module rstc_peer_model
  import rstc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       req,
  input  wire logic [1:0] kind,
  input  wire logic [4:0] id,
  output var rstc_event_type peer_evt
);
  // idle id keeps toggling so a stale id never matches by luck
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      peer_evt <= '0;
    end else begin
      peer_evt <= req ? '{1'b1, kind, id} : '{1'b0, ~kind, ~peer_evt.rail_id};
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// tb: self-checking bench for rstc_rail_seq with a peer controller model
// assumes a 40 MHz clock and a four-cycle reset at start
`timescale 1ns/1ps
`default_nettype none
module tb
  import rstc_pkg::*;
;
  logic clk = 0, nrst = 0, en = 0, grp = 0, done = 0, req = 0, rv, on, st, tr, ge;
  logic [1:0] kind = 0;
  logic [4:0] id = 0;
  logic [7:0] res;
  logic [15:0] gain, vref, fol = 16'h0640, so = 16'h8900;
  logic [31:0] rdata;
  rstc_cmd_type cmd = '0;
  rstc_event_type evt;
  int n_fail = 0, n_checks = 0, cyc = 0;
  rstc_rail_seq u_rstc_rail_seq (.CLK(clk), .NRST(nrst), .CMD(cmd), .RDATA(rdata), .RVALID(rv),
    .STRAP_RESIDUAL(8'h11), .STRAP_GAIN(16'h0222), .STRAP_ORDER(so), .AUTO_RESIDUAL(8'h33),
    .AUTO_GAIN(16'h0444), .ENABLE_STATE(en), .MULTI_GROUP(grp), .PEER_EVT(evt),
    .OFF_DELAY_DONE(done), .TARGET_VOLT(16'h03e8), .FOLLOW_VOLT(fol), .RAIL_ON(on),
    .OFF_DELAY_START(st), .LOOP_GAIN_EN(ge), .LOOP_RESIDUAL(res), .LOOP_GAIN(gain),
    .TRACK_ACTIVE(tr), .VOLT_REF(vref));
  rstc_peer_model u_rstc_peer_model (.clk(clk), .nrst(nrst), .req(req), .kind(kind), .id(id),
    .peer_evt(evt));
  always #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) cmd <= '{1'b1, 1'b0, a, d};
    @(posedge clk) cmd <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) cmd <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk) cmd <= '0;
    #1;
    chk({31'h0, rv}, 32'h1);
    chk(rdata, e);
  endtask
  task automatic ev(input logic [1:0] k, input logic [4:0] i);
    @(posedge clk) {req, kind, id} <= {1'b1, k, i};
    @(posedge clk) req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_regs;
    rd(LOOP_RESPONSE_OFS, 32'h0133_0444);
    rd(RAIL_ORDER_OFS, 32'h0);
    rd(VOLTAGE_FOLLOW_OFS, 32'h0);
    wr(LOOP_RESPONSE_OFS, 32'hffff_ffff);
    rd(LOOP_RESPONSE_OFS, 32'h01ff_ffff);
    wr(LOOP_RESPONSE_OFS, 32'h0032_01f4);
    chk({7'h0, ge, res, gain}, 32'h0032_01f4);
    wr(RAIL_ORDER_OFS, 32'hffff_ffff);
    rd(RAIL_ORDER_OFS, 32'h9f9f);
    rd(8'he3, 32'h0);
    wr(VOLTAGE_FOLLOW_OFS, 32'hff);
    rd(VOLTAGE_FOLLOW_OFS, 32'h86);
  endtask
  task automatic t_on;
    wr(RAIL_ORDER_OFS, 32'h8583);
    @(posedge clk) en <= 1'b1;
    ev(EVT_POWER_GOOD, 5'd9);
    ev(EVT_POWER_GOOD, 5'd4);
    chk({31'h0, on}, 32'h0);
    ev(EVT_POWER_GOOD, 5'd5);
    chk({31'h0, on}, 32'h1);
  endtask
  task automatic t_track;
    logic [7:0] c [5] = '{8'h80, 8'h84, 8'h82, 8'h86, 8'h00};
    logic [16:0] x [5] = '{17'h103e8, 17'h10320, 17'h10640, 17'h10320, 17'h003e8};
    for (int k = 0; k < 5; k++) begin
      wr(VOLTAGE_FOLLOW_OFS, {24'h0, c[k]});
      chk({15'h0, tr, vref}, {15'h0, x[k]});
    end
    @(posedge clk) grp <= 1'b1;
    wr(VOLTAGE_FOLLOW_OFS, 32'h80);
    chk({31'h0, tr}, 32'h0);
  endtask
  task automatic t_off;
    ev(EVT_POWER_DOWN, 5'd7);
    chk({30'h0, st, on}, 32'h1);
    // the shutdown pulse stands one cycle, so look right after the event edge
    @(posedge clk) {req, kind, id} <= {1'b1, EVT_POWER_DOWN, 5'd3};
    @(posedge clk) req <= 1'b0;
    @(posedge clk) #1;
    chk({30'h0, st, on}, 32'h3);
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    @(posedge clk) #1;
    chk({31'h0, on}, 32'h0);
  endtask
  task automatic final_report;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      final_report;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs;
    t_on;
    t_track;
    t_off;
    final_report;
  end
endmodule
`default_nettype wire
